/* rtl/thbp_regs.svh */
/*
 * Register map constants for the timer host bus port.
 * Assumes inclusion by the port logic only; definitions only.
 */
`ifndef THBP_REGS_SVH
`define THBP_REGS_SVH

`define THBP_DB_W 16
`define THBP_NUM_CNT 5
`define THBP_PTR_W 5
`define THBP_BYTE_W 8
`define THBP_AUX_LSB 8
`define THBP_AUX_MSB 12
`define THBP_HOLD_LSB 13
`define THBP_HOLD_MSB 15
`define THBP_HOLD_HIGH 3'h7
`define THBP_PTR_CMD_MSB 7
`define THBP_PTR_CMD_LSB 5
`define THBP_PTR_CMD_CODE 3'h0
`define THBP_CMD_BUS_WIDE 8'he8
`define THBP_MM_PTR 5'h17
`define THBP_STATUS_PTR 5'h1f
`define THBP_MM_WIDTH_BIT 14
`define THBP_PTR_RST 5'h00
`define THBP_CMD_RST 8'h00
`define THBP_DB_RST 16'h0000
`define THBP_OE_OFF 16'hffff
`define THBP_OE_WIDE 16'h0000
`define THBP_OE_NARROW 16'hff00
`define THBP_AUX_IDLE 5'h1f
`define THBP_SYNC_CTL_IDLE 4'he
`define THBP_DB_IDLE 16'hff00

`endif

/* rtl/thbp_pkg.sv */
/*
 * Types shared by the timer host bus port.
 * Assumes nothing of its surroundings.
 */
package thbp_pkg;

  // Strobe handling states, one bit changes per step from idle
  typedef enum logic [1:0] {
    THBP_ST_IDLE = 2'h0,
    THBP_ST_RD = 2'h1,
    THBP_ST_WR = 2'h2
  } thbp_state_t;

endpackage : thbp_pkg

/* rtl/thbp_reg_mem.sv */
/*
 * Internal register store reached through the data port pointer.
 * Assumes one synchronous write port and a registered read at the pointer.
 */
`timescale 1ns/1ns
module thbp_reg_mem #(
  parameter int ADDR_W = 5,
  parameter int DATA_W = 16
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic we_i,
  input wire logic [ADDR_W-1:0] waddr_i,
  input wire logic [DATA_W-1:0] wdata_i,
  input wire logic [ADDR_W-1:0] raddr_i,
  output logic [DATA_W-1:0] rdata_o
);

  logic [DATA_W-1:0] mem_reg [0:(1<<ADDR_W)-1];

  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem_reg[waddr_i] <= wdata_i;
    end
  end

  // Write-through so a read right after a write sees new data
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_o <= '0;
    end else if (we_i && waddr_i == raddr_i) begin
      rdata_o <= wdata_i;
    end else begin
      rdata_o <= mem_reg[raddr_i];
    end
  end

endmodule : thbp_reg_mem

/* rtl/thbp_host_port.sv */
/*
 * Host parallel bus port of a five counter timing controller.
 * Assumes strobes and data bus arrive asynchronously and are sampled
 * on clk_i; counter logic sits outside and reads the outputs here.
 */
`timescale 1ns/1ns
`include "thbp_regs.svh"
module thbp_host_port #(
  parameter int NUM_CNT = `THBP_NUM_CNT,
  parameter int DB_W = `THBP_DB_W,
  parameter int PTR_W = `THBP_PTR_W
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic cs_n_i,
  input wire logic rd_n_i,
  input wire logic wr_n_i,
  input wire logic ctrl_sel_i,
  input wire logic [DB_W-1:0] db_i,
  output logic [DB_W-1:0] db_o,
  output logic [DB_W-1:0] db_oe_n_o,
  input wire logic [7:0] status_i,
  input wire logic [NUM_CNT-1:0] count_source_input_i,
  input wire logic [NUM_CNT-1:0] gate_i,
  input wire logic [NUM_CNT-1:0] counter_out_i,
  input wire logic divided_freq_i,
  output logic [NUM_CNT-1:0] count_source_o,
  output logic [NUM_CNT-1:0] gate_o,
  output logic [NUM_CNT-1:0] counter_out_o,
  output logic divided_freq_output_o,
  output logic [NUM_CNT-1:0] aux_gate_line_n_o,
  output logic bus_width_bit_o,
  output logic [7:0] cmd_o,
  output logic cmd_valid_o,
  output logic [PTR_W-1:0] ptr_o,
  output logic reg_wr_valid_o,
  output logic [PTR_W-1:0] reg_wr_addr_o,
  output logic [DB_W-1:0] reg_wr_data_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers

  localparam int SYNC_W = 4 + DB_W + 2 * NUM_CNT;

  logic [SYNC_W-1:0] sync1_reg;
  logic [SYNC_W-1:0] sync2_reg;
  logic cs_n_s;
  logic rd_n_s;
  logic wr_n_s;
  logic ctrl_s;
  logic [DB_W-1:0] db_s;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync1_reg <= {`THBP_SYNC_CTL_IDLE, `THBP_DB_IDLE, {(2*NUM_CNT){1'b0}}};
      sync2_reg <= {`THBP_SYNC_CTL_IDLE, `THBP_DB_IDLE, {(2*NUM_CNT){1'b0}}};
    end else begin
      sync1_reg <= {cs_n_i, rd_n_i, wr_n_i, ctrl_sel_i, db_i, count_source_input_i, gate_i};
      sync2_reg <= sync1_reg;
    end
  end

  assign cs_n_s = sync2_reg[SYNC_W-1];
  assign rd_n_s = sync2_reg[SYNC_W-2];
  assign wr_n_s = sync2_reg[SYNC_W-3];
  assign ctrl_s = sync2_reg[SYNC_W-4];
  assign db_s = sync2_reg[2*NUM_CNT +: DB_W];

  // Pin side counter signals to counter logic
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count_source_o <= '0;
      gate_o <= '0;
      counter_out_o <= '0;
      divided_freq_output_o <= 1'b0;
    end else begin
      count_source_o <= sync2_reg[NUM_CNT +: NUM_CNT];
      gate_o <= sync2_reg[0 +: NUM_CNT];
      counter_out_o <= counter_out_i;
      divided_freq_output_o <= divided_freq_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Strobe qualification and access state

  logic rd_q;
  logic wr_q;
  logic rd_fire;
  logic wr_fire;
  thbp_pkg::thbp_state_t state_reg;
  thbp_pkg::thbp_state_t state_next;

  assign rd_q = !cs_n_s && !rd_n_s;
  assign wr_q = !cs_n_s && !wr_n_s;
  // Overlapping strobes are left alone
  assign rd_fire = (state_reg == thbp_pkg::THBP_ST_IDLE) && rd_q && !wr_q;
  assign wr_fire = (state_reg == thbp_pkg::THBP_ST_IDLE) && wr_q && !rd_q;

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      thbp_pkg::THBP_ST_IDLE: begin
        if (rd_fire) begin
          state_next = thbp_pkg::THBP_ST_RD;
        end else if (wr_fire) begin
          state_next = thbp_pkg::THBP_ST_WR;
        end
      end
      thbp_pkg::THBP_ST_RD: begin
        if (!rd_q) begin
          state_next = thbp_pkg::THBP_ST_IDLE;
        end
      end
      thbp_pkg::THBP_ST_WR: begin
        if (!wr_q) begin
          state_next = thbp_pkg::THBP_ST_IDLE;
        end
      end
      default: begin
        state_next = thbp_pkg::THBP_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= thbp_pkg::THBP_ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control port: command, pointer and width

  logic ptr_load;
  logic wide_cmd;
  logic data_wr;
  logic mem_we;
  logic [DB_W-1:0] mem_wdata;
  logic [DB_W-1:0] mem_rdata;
  logic byte_hi_reg;
  logic [7:0] low_byte_reg;

  assign ptr_load = wr_fire && ctrl_s &&
    (db_s[`THBP_PTR_CMD_MSB:`THBP_PTR_CMD_LSB] == `THBP_PTR_CMD_CODE);
  assign wide_cmd = wr_fire && ctrl_s && (db_s[7:0] == `THBP_CMD_BUS_WIDE) &&
    (db_s[`THBP_HOLD_MSB:`THBP_HOLD_LSB] == `THBP_HOLD_HIGH);
  assign data_wr = wr_fire && !ctrl_s;
  assign mem_we = data_wr && (bus_width_bit_o || byte_hi_reg);
  assign mem_wdata = bus_width_bit_o ? db_s : {db_s[7:0], low_byte_reg};

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cmd_o <= `THBP_CMD_RST;
      cmd_valid_o <= 1'b0;
    end else begin
      cmd_valid_o <= wr_fire && ctrl_s && !ptr_load;
      if (wr_fire && ctrl_s && !ptr_load) begin
        cmd_o <= db_s[7:0];
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ptr_o <= `THBP_PTR_RST;
    end else if (ptr_load) begin
      ptr_o <= db_s[PTR_W-1:0];
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bus_width_bit_o <= 1'b0;
    end else if (wide_cmd) begin
      bus_width_bit_o <= 1'b1;
    end else if (mem_we && ptr_o == `THBP_MM_PTR) begin
      bus_width_bit_o <= mem_wdata[`THBP_MM_WIDTH_BIT];
    end
  end

  // Narrow bus: low byte first, high byte commits the word
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      byte_hi_reg <= 1'b0;
      low_byte_reg <= 8'h00;
    end else if (ptr_load) begin
      byte_hi_reg <= 1'b0;
    end else if (!bus_width_bit_o && ((data_wr) || (rd_fire && !ctrl_s))) begin
      byte_hi_reg <= !byte_hi_reg;
      if (data_wr && !byte_hi_reg) begin
        low_byte_reg <= db_s[7:0];
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      reg_wr_valid_o <= 1'b0;
      reg_wr_addr_o <= `THBP_PTR_RST;
      reg_wr_data_o <= `THBP_DB_RST;
    end else begin
      reg_wr_valid_o <= mem_we;
      if (mem_we) begin
        reg_wr_addr_o <= ptr_o;
        reg_wr_data_o <= mem_wdata;
      end
    end
  end

  thbp_reg_mem #(
    .ADDR_W(PTR_W),
    .DATA_W(DB_W)
  ) u_mem (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .we_i(mem_we),
    .waddr_i(ptr_o),
    .wdata_i(mem_wdata),
    .raddr_i(ptr_o),
    .rdata_o(mem_rdata)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Read path and bus drive

  logic [DB_W-1:0] rd_word;
  logic [DB_W-1:0] rd_bus;

  always_comb begin
    if (ctrl_s || ptr_o == `THBP_STATUS_PTR) begin
      rd_word = {8'h00, status_i};
    end else begin
      rd_word = mem_rdata;
    end
    if (bus_width_bit_o) begin
      rd_bus = rd_word;
    end else begin
      rd_bus = {8'h00, byte_hi_reg ? rd_word[15:8] : rd_word[7:0]};
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      db_o <= `THBP_DB_RST;
      db_oe_n_o <= `THBP_OE_OFF;
    end else if (rd_fire) begin
      db_o <= rd_bus;
      db_oe_n_o <= bus_width_bit_o ? `THBP_OE_WIDE : `THBP_OE_NARROW;
    end else if (!rd_q) begin
      db_oe_n_o <= `THBP_OE_OFF;
    end
  end

  // Upper lines as gate enables in narrow mode
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      aux_gate_line_n_o <= `THBP_AUX_IDLE;
    end else if (bus_width_bit_o) begin
      aux_gate_line_n_o <= `THBP_AUX_IDLE;
    end else begin
      aux_gate_line_n_o <= db_s[`THBP_AUX_MSB:`THBP_AUX_LSB];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  a_float_no_cs: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $past(cs_n_s) |-> db_oe_n_o == `THBP_OE_OFF)
    else $error("bus driven without chip select");
  a_drive_on_read: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    rd_fire |=> db_oe_n_o != `THBP_OE_OFF && db_o == $past(rd_bus))
    else $error("qualified read not driven");
  a_narrow_upper: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !bus_width_bit_o |-> db_oe_n_o[15:8] == 8'hff)
    else $error("upper lines driven in narrow mode");
  a_status_read: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    rd_fire && ctrl_s && bus_width_bit_o |=> db_o == {8'h00, $past(status_i)})
    else $error("control read not status");
  a_cmd_once: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    cmd_valid_o |=> !cmd_valid_o)
    else $error("command issued twice");
  a_ptr_load: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ptr_load |=> ptr_o == $past(db_s[PTR_W-1:0]) && !cmd_valid_o)
    else $error("pointer not loaded");
  a_no_wr_no_cs: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    cs_n_s |=> !reg_wr_valid_o && !cmd_valid_o)
    else $error("write taken without chip select");
  a_data_wr_addr: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    mem_we |=> reg_wr_valid_o && reg_wr_addr_o == $past(ptr_o))
    else $error("data write to wrong location");
  a_wide_cmd: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    wide_cmd |=> bus_width_bit_o)
    else $error("width command ignored");
  a_aux_wide: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $past(bus_width_bit_o) |-> aux_gate_line_n_o == `THBP_AUX_IDLE)
    else $error("aux gate active in wide mode");

endmodule : thbp_host_port

/* tb/thbp_host_model.sv */
/*
 * Host processor model for the timer host bus port.
 * Assumes the bench calls access() and that the bus is resolved here.
 */
`timescale 1ns/1ns
module thbp_host_model (
  input wire logic clk_i,
  input wire logic [15:0] db_o_i,
  input wire logic [15:0] db_oe_n_i,
  output logic cs_n_o,
  output logic rd_n_o,
  output logic wr_n_o,
  output logic ctrl_sel_o,
  output logic [15:0] db_pin_o
);
  logic [15:0] drv = 16'h0000;
  logic [15:0] last = 16'h0000;
  logic [15:0] host_val;
  logic drv_en = 1'b0;
  logic wide = 1'b0;
  logic [4:0] aux = 5'h1f;
  initial begin
    cs_n_o = 1'b1;
    rd_n_o = 1'b1;
    wr_n_o = 1'b1;
    ctrl_sel_o = 1'b0;
  end
  // Undriven lines flip every cycle; narrow mode keeps lines 15:13 high and puts aux on lines 12:8
  assign host_val = {(!wide ? {3'h7, aux} : (drv_en ? drv[15:8] : ~last[15:8])),
                     (drv_en ? drv[7:0] : ~last[7:0])};
  assign db_pin_o = (db_o_i & ~db_oe_n_i) | (host_val & db_oe_n_i);
  always @(posedge clk_i) last <= db_pin_o;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic access(input logic sel, input logic ctrl, input logic wr,
                        input logic [15:0] d, output logic [15:0] q, output logic [15:0] oe);
    @(negedge clk_i);
    cs_n_o = ~sel;
    ctrl_sel_o = ctrl;
    drv = d;
    drv_en = wr;
    repeat (3) @(negedge clk_i);
    // Only one strobe per access
    if (wr) begin
      wr_n_o = 1'b0;
    end else begin
      rd_n_o = 1'b0;
    end
    repeat (5) @(negedge clk_i);
    q = db_pin_o;
    oe = db_oe_n_i;
    rd_n_o = 1'b1;
    wr_n_o = 1'b1;
    repeat (4) @(negedge clk_i);
    drv_en = 1'b0;
    cs_n_o = 1'b1;
  endtask : access
endmodule : thbp_host_model

/* tb/testbench.sv */
/*
 * Self-checking bench for the timer host bus port.
 * Assumes the host model drives the bus and strobes.
 */
`timescale 1ns/1ns
module testbench;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cs_n, rd_n, wr_n, ctrl_sel, div_i = 1'b0, div_o, bw, cmd_v, reg_v;
  logic [15:0] db_pin, db_o, db_oe_n, q, oe, reg_d;
  logic [7:0] status = 8'h00, cmd;
  logic [4:0] cnt_in = 5'h00, gate = 5'h00, cout = 5'h00;
  logic [4:0] cnt_in_o, gate_o, cout_o, aux_n, ptr, reg_a;
  int err_total = 0;
  int tests_run = 0;
  int cmd_cnt = 0;
  int reg_cnt = 0;
  always #5 clk = ~clk;
  thbp_host_port i_dut (.clk_i(clk), .rst_n_i(rst_n), .cs_n_i(cs_n), .rd_n_i(rd_n),
    .wr_n_i(wr_n), .ctrl_sel_i(ctrl_sel), .db_i(db_pin), .db_o(db_o), .db_oe_n_o(db_oe_n),
    .status_i(status), .count_source_input_i(cnt_in), .gate_i(gate), .counter_out_i(cout),
    .divided_freq_i(div_i), .count_source_o(cnt_in_o), .gate_o(gate_o), .counter_out_o(cout_o),
    .divided_freq_output_o(div_o), .aux_gate_line_n_o(aux_n), .bus_width_bit_o(bw),
    .cmd_o(cmd), .cmd_valid_o(cmd_v), .ptr_o(ptr), .reg_wr_valid_o(reg_v),
    .reg_wr_addr_o(reg_a), .reg_wr_data_o(reg_d));
  thbp_host_model u_host (.clk_i(clk), .db_o_i(db_o), .db_oe_n_i(db_oe_n), .cs_n_o(cs_n),
    .rd_n_o(rd_n), .wr_n_o(wr_n), .ctrl_sel_o(ctrl_sel), .db_pin_o(db_pin));
  always @(posedge clk) begin
    if (cmd_v === 1'b1) cmd_cnt++;
    if (reg_v === 1'b1) reg_cnt++;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %0t %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : check
  task automatic give_verdict;
    if (err_total == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : give_verdict
  task automatic t_reset;
    check(db_oe_n, 16'hffff, "idle enable");
    check(16'(bw), 16'h0000, "reset width");
    check(16'(ptr), 16'h0000, "reset pointer");
    check(16'(aux_n), 16'h001f, "reset aux");
  endtask : t_reset
  task automatic t_ctrl;
    int c;
    u_host.access(1'b1, 1'b1, 1'b1, 16'h0003, q, oe);
    check(16'(ptr), 16'h0003, "pointer load");
    c = cmd_cnt;
    u_host.access(1'b1, 1'b1, 1'b1, 16'h0045, q, oe);
    check(16'(cmd), 16'h0045, "command");
    check(16'(cmd_cnt - c), 16'h0001, "one commit");
    status = 8'h5a;
    u_host.access(1'b1, 1'b1, 1'b0, 16'h0000, q, oe);
    check(16'(q[7:0]), 16'h005a, "status read");
    check(oe, 16'hff00, "narrow drive");
    check(db_oe_n, 16'hffff, "released");
    u_host.access(1'b0, 1'b1, 1'b0, 16'h0000, q, oe);
    check(oe, 16'hffff, "read unselected");
    c = cmd_cnt;
    u_host.access(1'b0, 1'b1, 1'b1, 16'h0077, q, oe);
    check(16'(cmd_cnt - c), 16'h0000, "write unselected");
  endtask : t_ctrl
  task automatic t_narrow;
    int c;
    u_host.access(1'b1, 1'b1, 1'b1, 16'h0002, q, oe);
    c = reg_cnt;
    u_host.access(1'b1, 1'b0, 1'b1, 16'h0034, q, oe);
    u_host.access(1'b1, 1'b0, 1'b1, 16'h0012, q, oe);
    check(16'(reg_cnt - c), 16'h0001, "word commit");
    check({reg_a, reg_d[10:0]}, {5'h02, 11'h234}, "word addr");
    check(reg_d, 16'h1234, "word data");
    u_host.access(1'b1, 1'b0, 1'b0, 16'h0000, q, oe);
    check(16'(q[7:0]), 16'h0034, "low byte read");
    u_host.access(1'b1, 1'b0, 1'b0, 16'h0000, q, oe);
    check(16'(q[7:0]), 16'h0012, "high byte read");
    u_host.aux = 5'h0a;
    repeat (6) @(negedge clk);
    check(16'(aux_n), 16'h000a, "aux gate");
    u_host.aux = 5'h1f;
  endtask : t_narrow
  task automatic t_wide;
    u_host.access(1'b1, 1'b1, 1'b1, 16'h00e8, q, oe);
    check(16'(bw), 16'h0001, "width switch");
    u_host.wide = 1'b1;
    u_host.access(1'b1, 1'b1, 1'b1, 16'h0005, q, oe);
    u_host.access(1'b1, 1'b0, 1'b1, 16'ha5c3, q, oe);
    check(reg_d, 16'ha5c3, "wide write");
    check(16'(reg_a), 16'h0005, "wide addr");
    check(16'(aux_n), 16'h001f, "aux off wide");
    u_host.access(1'b1, 1'b0, 1'b0, 16'h0000, q, oe);
    check(q, 16'ha5c3, "wide read");
    check(oe, 16'h0000, "wide drive");
    u_host.access(1'b1, 1'b1, 1'b0, 16'h0000, q, oe);
    check(q, 16'h005a, "wide status read");
    u_host.access(1'b1, 1'b1, 1'b1, 16'h001f, q, oe);
    u_host.access(1'b1, 1'b0, 1'b0, 16'h0000, q, oe);
    check(q, 16'h005a, "status via pointer");
    u_host.access(1'b1, 1'b1, 1'b1, 16'h0017, q, oe);
    u_host.access(1'b1, 1'b0, 1'b1, 16'h1f00, q, oe);
    check(16'(bw), 16'h0000, "width bit clear");
    check(16'(reg_a), 16'h0017, "mode addr");
    u_host.wide = 1'b0;
  endtask : t_wide
  task automatic t_pins;
    @(negedge clk);
    cnt_in = 5'h15;
    gate = 5'h0a;
    cout = 5'h13;
    div_i = 1'b1;
    repeat (4) @(negedge clk);
    check({cnt_in_o, gate_o, cout_o, div_o}, {5'h15, 5'h0a, 5'h13, 1'b1}, "pins");
  endtask : t_pins
  initial begin
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    t_reset();
    t_ctrl();
    t_narrow();
    t_wide();
    t_pins();
    give_verdict();
  end
  initial begin
    #100000;
    err_total++;
    give_verdict();
  end
endmodule : testbench
